// ---- pdc_divider_config.v ----
`include "pdc_defines.vh"
`default_nettype none

// generic counting divider: one tick out per ratio ticks in
module pdc_div #(
	parameter W = 21
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// input tick and ratio
	input wire en,
	input wire [W-1:0] ratio,
	// divided tick
	output reg tick_q
);
	reg [W-1:0] cnt_q; // counts input ticks
	// count, wrap at ratio-1; a ratio of 0 or 1 passes every tick
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
			tick_q <= 1'b0;
		end else if (en) begin
			if (ratio <= {{(W-1){1'b0}}, 1'b1} || cnt_q >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
				cnt_q <= {W{1'b0}};
				tick_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				tick_q <= 1'b0;
			end
		end else begin
			tick_q <= 1'b0;
		end
	end
endmodule

// divider configuration registers and the divider chains they steer
module pdc_divider_config #(
	parameter W = 21
) (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// register access port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	output reg [7:0] reg_rdata_q,
	// reference input pins
	input wire first_reference_input,
	input wire second_reference_input,
	// divided clock ticks
	output wire first_output_clock,
	output wire second_output_clock,
	output wire phase_detect_tick,
	output wire input1_div_tick,
	output wire input2_div_tick
);
	// reset synchroniser
	reg rst_meta_q;
	reg rst_n_q;
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// register storage
	reg [7:0] out_hs_q;
	reg [7:0] out1_hi_q;
	reg [7:0] out1_mid_q;
	reg [7:0] out1_lo_q;
	reg [7:0] out2_hi_q;
	reg [7:0] out2_mid_q;
	reg [7:0] out2_lo_q;
	reg [7:0] fb_hi_q;
	reg [7:0] fb_mid_q;
	reg [7:0] fb_lo_q;
	reg [7:0] in1_hi_q;
	reg [7:0] in1_mid_q;
	reg [7:0] in1_lo_q;
	reg [7:0] in2_hi_q;
	reg [7:0] in2_mid_q;
	reg [7:0] in2_lo_q;

	// highspeed code to ratio, base four
	function [W-1:0] hs_ratio;
		input [2:0] code;
		begin
			hs_ratio = `PDC_HS_BASE + {{(W-3){1'b0}}, code};
		end
	endfunction

	// output lowspeed field to ratio: zero means one, else field plus one
	function [W-1:0] ols_ratio;
		input [19:0] field;
		begin
			if (field == 20'h00000)
				ols_ratio = {{(W-1){1'b0}}, 1'b1};
			else
				ols_ratio = {1'b0, field} + {{(W-1){1'b0}}, 1'b1};
		end
	endfunction

	// register writes
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			out_hs_q <= `PDC_RST_OUT_HS;
			out1_hi_q <= `PDC_RST_OUT1_HI;
			out1_mid_q <= `PDC_RST_OUT1_MID;
			out1_lo_q <= `PDC_RST_OUT1_LO;
			out2_hi_q <= `PDC_RST_OUT2_HI;
			out2_mid_q <= `PDC_RST_OUT2_MID;
			out2_lo_q <= `PDC_RST_OUT2_LO;
			fb_hi_q <= `PDC_RST_FB_HI;
			fb_mid_q <= `PDC_RST_FB_MID;
			fb_lo_q <= `PDC_RST_FB_LO;
			in1_hi_q <= `PDC_RST_IN1_HI;
			in1_mid_q <= `PDC_RST_IN1_MID;
			in1_lo_q <= `PDC_RST_IN1_LO;
			in2_hi_q <= `PDC_RST_IN2_HI;
			in2_mid_q <= `PDC_RST_IN2_MID;
			in2_lo_q <= `PDC_RST_IN2_LO;
		end else if (reg_wr) begin
			case (reg_addr)
				`PDC_OFS_OUT_HS: out_hs_q <= reg_wdata & `PDC_MSK_HS_ONLY;
				`PDC_OFS_OUT1_HI: out1_hi_q <= reg_wdata & `PDC_MSK_NIBBLE;
				`PDC_OFS_OUT1_MID: out1_mid_q <= reg_wdata;
				`PDC_OFS_OUT1_LO: out1_lo_q <= reg_wdata;
				`PDC_OFS_OUT2_HI: out2_hi_q <= reg_wdata & `PDC_MSK_NIBBLE;
				`PDC_OFS_OUT2_MID: out2_mid_q <= reg_wdata;
				`PDC_OFS_OUT2_LO: out2_lo_q <= reg_wdata;
				`PDC_OFS_FB_HI: fb_hi_q <= reg_wdata & `PDC_MSK_FB_HI;
				`PDC_OFS_FB_MID: fb_mid_q <= reg_wdata;
				`PDC_OFS_FB_LO: fb_lo_q <= reg_wdata;
				`PDC_OFS_IN1_HI: in1_hi_q <= reg_wdata & `PDC_MSK_IN_HI;
				`PDC_OFS_IN1_MID: in1_mid_q <= reg_wdata;
				`PDC_OFS_IN1_LO: in1_lo_q <= reg_wdata;
				`PDC_OFS_IN2_HI: in2_hi_q <= reg_wdata & `PDC_MSK_IN_HI;
				`PDC_OFS_IN2_MID: in2_mid_q <= reg_wdata;
				`PDC_OFS_IN2_LO: in2_lo_q <= reg_wdata;
				default: out_hs_q <= out_hs_q; // unmapped writes ignored
			endcase
		end
	end

	// read mux, one cycle latency, unmapped reads as zero
	reg [7:0] rdata_d;
	always @* begin
		case (reg_addr)
			`PDC_OFS_OUT_HS: rdata_d = out_hs_q;
			`PDC_OFS_OUT1_HI: rdata_d = out1_hi_q;
			`PDC_OFS_OUT1_MID: rdata_d = out1_mid_q;
			`PDC_OFS_OUT1_LO: rdata_d = out1_lo_q;
			`PDC_OFS_OUT2_HI: rdata_d = out2_hi_q;
			`PDC_OFS_OUT2_MID: rdata_d = out2_mid_q;
			`PDC_OFS_OUT2_LO: rdata_d = out2_lo_q;
			`PDC_OFS_FB_HI: rdata_d = fb_hi_q;
			`PDC_OFS_FB_MID: rdata_d = fb_mid_q;
			`PDC_OFS_FB_LO: rdata_d = fb_lo_q;
			`PDC_OFS_IN1_HI: rdata_d = in1_hi_q;
			`PDC_OFS_IN1_MID: rdata_d = in1_mid_q;
			`PDC_OFS_IN1_LO: rdata_d = in1_lo_q;
			`PDC_OFS_IN2_HI: rdata_d = in2_hi_q;
			`PDC_OFS_IN2_MID: rdata_d = in2_mid_q;
			`PDC_OFS_IN2_LO: rdata_d = in2_lo_q;
			default: rdata_d = 8'h00;
		endcase
	end
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			reg_rdata_q <= 8'h00;
		else
			reg_rdata_q <= rdata_d;
	end

	// assembled ratio fields
	wire [19:0] out1_lowspeed_ratio;
	wire [19:0] out2_lowspeed_ratio;
	wire [19:0] feedback_lowspeed_ratio;
	wire [2:0] feedback_highspeed_ratio;
	wire [2:0] output_highspeed_ratio;
	wire [18:0] input1_prescale_ratio;
	wire [18:0] input2_prescale_ratio;
	assign out1_lowspeed_ratio = {out1_hi_q[3:0], out1_mid_q, out1_lo_q};
	assign out2_lowspeed_ratio = {out2_hi_q[3:0], out2_mid_q, out2_lo_q};
	assign feedback_lowspeed_ratio = {fb_hi_q[3:0], fb_mid_q, fb_lo_q};
	assign feedback_highspeed_ratio = fb_hi_q[7:5];
	assign output_highspeed_ratio = out_hs_q[7:5];
	assign input1_prescale_ratio = {in1_hi_q[2:0], in1_mid_q, in1_lo_q};
	assign input2_prescale_ratio = {in2_hi_q[2:0], in2_mid_q, in2_lo_q};

	// decoded ratios
	wire [W-1:0] ohs_div;
	wire [W-1:0] fhs_div;
	wire [W-1:0] o1_div;
	wire [W-1:0] o2_div;
	wire [W-1:0] fls_div;
	wire [W-1:0] i1_div;
	wire [W-1:0] i2_div;
	assign ohs_div = hs_ratio(output_highspeed_ratio);
	assign fhs_div = hs_ratio(feedback_highspeed_ratio);
	assign o1_div = ols_ratio(out1_lowspeed_ratio);
	assign o2_div = ols_ratio(out2_lowspeed_ratio);
	assign fls_div = {1'b0, feedback_lowspeed_ratio} + {{(W-1){1'b0}}, 1'b1};
	assign i1_div = {2'b00, input1_prescale_ratio} + {{(W-1){1'b0}}, 1'b1};
	assign i2_div = {2'b00, input2_prescale_ratio} + {{(W-1){1'b0}}, 1'b1};

	// reference pin synchronisers and rising edge detect
	reg [2:0] ref1_s_q;
	reg [2:0] ref2_s_q;
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ref1_s_q <= 3'b000;
			ref2_s_q <= 3'b000;
		end else begin
			ref1_s_q <= {ref1_s_q[1:0], first_reference_input};
			ref2_s_q <= {ref2_s_q[1:0], second_reference_input};
		end
	end
	wire ref1_rise;
	wire ref2_rise;
	assign ref1_rise = ref1_s_q[1] & ~ref1_s_q[2];
	assign ref2_rise = ref2_s_q[1] & ~ref2_s_q[2];

	// divider chains
	wire ohs_tick;
	wire fhs_tick;
	// shared highspeed stage
	// runs on every clock, feeds both output lowspeed stages
	pdc_div #(.W(W)) u_ohs (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(1'b1),
		.ratio(ohs_div),
		.tick_q(ohs_tick)
	);
	// first output lowspeed stage, steps on highspeed ticks
	pdc_div #(.W(W)) u_o1 (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(ohs_tick),
		.ratio(o1_div),
		.tick_q(first_output_clock)
	);
	// second output lowspeed stage, same highspeed source
	pdc_div #(.W(W)) u_o2 (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(ohs_tick),
		.ratio(o2_div),
		.tick_q(second_output_clock)
	);
	// feedback highspeed stage, runs on every clock
	pdc_div #(.W(W)) u_fhs (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(1'b1),
		.ratio(fhs_div),
		.tick_q(fhs_tick)
	);
	// highspeed into lowspeed
	// its tick is what the phase detector compares
	pdc_div #(.W(W)) u_fls (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(fhs_tick),
		.ratio(fls_div),
		.tick_q(phase_detect_tick)
	);
	// first reference prescaler, counts synchronised rising edges
	pdc_div #(.W(W)) u_i1 (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(ref1_rise),
		.ratio(i1_div),
		.tick_q(input1_div_tick)
	);
	// second reference prescaler, counts synchronised rising edges
	pdc_div #(.W(W)) u_i2 (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.en(ref2_rise),
		.ratio(i2_div),
		.tick_q(input2_div_tick)
	);
endmodule

`default_nettype wire

// ---- pdc_defines.vh ----
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
// register offsets
`define PDC_OFS_OUT_HS 8'h19
`define PDC_OFS_OUT1_HI 8'h1f
`define PDC_OFS_OUT1_MID 8'h20
`define PDC_OFS_OUT1_LO 8'h21
`define PDC_OFS_OUT2_HI 8'h22
`define PDC_OFS_OUT2_MID 8'h23
`define PDC_OFS_OUT2_LO 8'h24
`define PDC_OFS_FB_HI 8'h28
`define PDC_OFS_FB_MID 8'h29
`define PDC_OFS_FB_LO 8'h2a
`define PDC_OFS_IN1_HI 8'h2b
`define PDC_OFS_IN1_MID 8'h2c
`define PDC_OFS_IN1_LO 8'h2d
`define PDC_OFS_IN2_HI 8'h2e
`define PDC_OFS_IN2_MID 8'h2f
`define PDC_OFS_IN2_LO 8'h30
// writable bit masks
`define PDC_MSK_HS_ONLY 8'he0
`define PDC_MSK_NIBBLE 8'h0f
`define PDC_MSK_FB_HI 8'hef
`define PDC_MSK_IN_HI 8'h07
`define PDC_MSK_FULL 8'hff
// reset values
`define PDC_RST_OUT_HS 8'h20
`define PDC_RST_OUT1_HI 8'h00
`define PDC_RST_OUT1_MID 8'h00
`define PDC_RST_OUT1_LO 8'h31
`define PDC_RST_OUT2_HI 8'h00
`define PDC_RST_OUT2_MID 8'h00
`define PDC_RST_OUT2_LO 8'h31
`define PDC_RST_FB_HI 8'hc0
`define PDC_RST_FB_MID 8'h00
`define PDC_RST_FB_LO 8'hf9
`define PDC_RST_IN1_HI 8'h00
`define PDC_RST_IN1_MID 8'h00
`define PDC_RST_IN1_LO 8'h09
`define PDC_RST_IN2_HI 8'h00
`define PDC_RST_IN2_MID 8'h00
`define PDC_RST_IN2_LO 8'h00
// highspeed ratio base for code 000
`define PDC_HS_BASE 21'h000004
`endif

// ---- pdc_divider_config_sva.sv ----
`default_nettype none
// port-level checks on the divider register block
module pdc_divider_config_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata_q,
	// divided ticks
	input wire logic first_output_clock,
	input wire logic phase_detect_tick
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	// a byte written to the out1 low byte is what a read of the same place returns
	a_out1_low_rw: assert property (
		(reg_wr && reg_addr == 8'h21) ##1 reg_addr == 8'h21 |=> reg_rdata_q == $past(reg_wdata, 2))
		else $error("out1 low byte readback wrong");
	// reserved bits never read back as one
	a_out2_hi_zero: assert property (reg_addr == 8'h22 |=> reg_rdata_q[7:4] == 4'h0)
		else $error("out2 high reserved set");
	a_fb_res_zero: assert property (reg_addr == 8'h28 |=> reg_rdata_q[4] == 1'b0)
		else $error("fb reserved bit set");
	a_in1_hi_zero: assert property (reg_addr == 8'h2b |=> reg_rdata_q[7:3] == 5'h00)
		else $error("in1 high reserved set");
	a_in2_hi_zero: assert property (reg_addr == 8'h2e |=> reg_rdata_q[7:3] == 5'h00)
		else $error("in2 high reserved set");
	a_hs_low_zero: assert property (reg_addr == 8'h19 |=> reg_rdata_q[4:0] == 5'h00)
		else $error("hs reserved bits set");
	a_unmapped_zero: assert property (reg_addr == 8'h00 |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	// the highspeed stage alone divides by four at least
	a_out1_gap: assert property (first_output_clock |=> !first_output_clock [*3])
		else $error("out1 ticks too close");
	a_pd_gap: assert property (phase_detect_tick |=> !phase_detect_tick [*3])
		else $error("detector ticks too close");
endmodule
bind pdc_divider_config pdc_divider_config_sva chk (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q),
	.first_output_clock(first_output_clock), .phase_detect_tick(phase_detect_tick));
`default_nettype wire

// ---- test_pdc_divider_config.sv ----
`default_nettype none
// register model and tick period bench for the divider block
module test_pdc_divider_config;
	timeunit 1ns;
	timeprecision 1ps;
	// driven inputs
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic [1:0] ph = 2'h0;
	// observed outputs
	wire [7:0] reg_rdata_q;
	wire [4:0] tk;
	// counters and model: table holds reset value and writable mask
	int fails = 0;
	int samples_checked = 0;
	logic [7:0] mdl [0:255];
	logic [7:0] msk [0:255];
	logic [7:0] offs [18] = '{8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29,
		8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h00, 8'h31};
	logic [15:0] tbl [16] = '{16'h20e0, 16'h000f, 16'h00ff, 16'h31ff, 16'h000f, 16'h00ff, 16'h31ff, 16'hc0ef,
		16'h00ff, 16'hf9ff, 16'h0007, 16'h00ff, 16'h09ff, 16'h0007, 16'h00ff, 16'h00ff};
	int f;
	always #20 ref_clk = ~ref_clk;
	// both reference pins run at a quarter of the clock
	always @(negedge ref_clk) begin
		ph <= ph + 2'h1;
	end
	pdc_divider_config dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q), .first_reference_input(ph[1]),
		.second_reference_input(~ph[1]), .first_output_clock(tk[0]), .second_output_clock(tk[1]),
		.phase_detect_tick(tk[2]), .input1_div_tick(tk[3]), .input2_div_tick(tk[4]));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one write strobe, model keeps only the writable bits
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		mdl[a] = d & msk[a];
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		@(negedge ref_clk);
		check("reg_rdata_q", reg_rdata_q, mdl[a]);
	endtask
	// clocks between two ticks, after two ticks to settle
	task automatic period(input int w, input int exp);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (tk[w] !== 1'b1 && n < 400);
			if (n >= 400) begin
				fails++;
				tally_and_finish();
			end
		end
		check("tick period", n, exp);
	endtask
	initial begin
		void'($urandom(95805));
		for (int i = 0; i < 256; i++) begin
			mdl[i] = 8'h00;
			msk[i] = 8'h00;
		end
		for (int i = 0; i < 16; i++) begin
			{mdl[offs[i]], msk[offs[i]]} = tbl[i];
		end
		repeat (4) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		// reset contents, then random bytes with reserved bits dropped
		for (int i = 0; i < 18; i++) begin
			rd(offs[i]);
		end
		for (int i = 0; i < 18; i++) begin
			// lowspeed low bytes keep bit 0 set, so every field stays odd
			wr(offs[i], 8'($urandom) | ((offs[i] inside {8'h21, 8'h24, 8'h2a}) ? 8'h01 : 8'h00));
			rd(offs[i]);
		end
		// the feedback low byte never goes even while clearing
		for (int i = 1; i < 16; i++) begin
			wr(offs[i], (offs[i] == 8'h2a) ? 8'h01 : 8'h00);
		end
		wr(8'h24, 8'h03);
		// every highspeed code on outputs and feedback
		for (int c = 0; c < 8; c++) begin
			f = (c % 2) ? 5 : 0;
			wr(8'h19, 8'(c << 5));
			wr(8'h21, 8'(f));
			wr(8'h28, 8'(c << 5));
			period(0, (4 + c) * ((f == 0) ? 1 : f + 1));
			period(1, (4 + c) * 4);
			period(2, (4 + c) * 2);
		end
		// input dividers count reference rising edges
		for (int i = 0; i < 3; i++) begin
			f = $urandom % 4;
			wr(8'h2d, 8'(f));
			wr(8'h30, 8'(3 - f));
			period(3, (f + 1) * 4);
			period(4, (4 - f) * 4);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
